// File: dma_channel_pkg.sv
`default_nettype none
package dma_channel_pkg;

    localparam int unsigned num_channels = 8;
    localparam int unsigned addr_width   = 20;

    // register byte addresses
    localparam logic [11:0] vector_offset      = 12'h000;
    localparam logic [11:0] global_cfg_offset  = 12'h004;
    localparam logic [4:0]  channel_page       = 5'h01;
    localparam logic [1:0]  ctl_slot           = 2'h0;
    localparam logic [1:0]  src_slot           = 2'h1;
    localparam logic [1:0]  dst_slot           = 2'h2;
    localparam logic [1:0]  size_slot          = 2'h3;

    // channel_control field positions
    localparam int unsigned mode_lsb           = 12;
    localparam int unsigned dest_step_lsb      = 10;
    localparam int unsigned src_step_lsb       = 8;
    localparam int unsigned dest_width_pos     = 7;
    localparam int unsigned src_width_pos      = 6;
    localparam int unsigned trig_level_pos     = 5;
    localparam int unsigned enable_pos         = 4;
    localparam int unsigned done_pos           = 3;
    localparam int unsigned irq_enable_pos     = 2;
    localparam int unsigned abort_pos          = 1;
    localparam int unsigned soft_start_pos     = 0;
    localparam logic [15:0] ctl_write_mask     = 16'h7fff;
    localparam int unsigned nmi_stop_pos       = 0;

    // reset values
    localparam logic [15:0] ctl_reset          = 16'h0000;
    localparam logic [15:0] size_reset         = 16'h0000;
    localparam logic [19:0] addr_reset         = 20'h00000;

    // transfer modes and address steps
    localparam logic [2:0]  mode_single        = 3'h0;
    localparam logic [1:0]  step_dec           = 2'h2;
    localparam logic [1:0]  step_inc           = 2'h3;
    localparam int unsigned mode_repeat_bit    = 2;

    typedef enum logic [1:0] {
        mover_idle,
        mover_read,
        mover_write
    } mover_state_e;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        byte_access;
        logic [19:0] addr;
        logic [15:0] wdata;
    } mem_req_s;

endpackage : dma_channel_pkg
`default_nettype wire

// File: dma_channel_control.sv
// Operation
// - mode field picks single, block, burst, repeated
// - destination step: hold, decrement, increment
// - source steps a working copy likewise
// - destination width bit: 0 word, 1 byte
// - trigger: rising edge or high level
// - abort flag set when NMI stopped transfer
// - soft start bit starts, then self-clears
// - source register gives first source address
// - programmed source kept, working copy steps
// - address bits 31-20 zero, 19-16 extended
// - word write to source clears 19-16
// - destination register kept, gives first address
// - word write to destination clears 19-16
// - size counts down, reloads at zero
// - size zero disables, else units per block
// - vector 00h none, 02h-10h by priority
// - NMI stop: finish unit, stop, flag abort
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module dma_channel_control (
    // clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // apb slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // triggers and nmi from outside
    input  wire logic [7:0]                    trigger_in,
    input  wire logic                          nmi_in,
    // memory side master
    output dma_channel_pkg::mem_req_s          mem_req,
    input  wire logic                          mem_ack,
    input  wire logic [15:0]                   mem_rdata,
    // interrupt requests per channel
    output logic      [7:0]                    channel_irq
);

    logic [15:0] ctl       [8];
    logic [19:0] src_prog  [8];
    logic [19:0] dst_prog  [8];
    logic [19:0] src_work  [8];
    logic [19:0] dst_work  [8];
    logic [15:0] sz_prog   [8];
    logic [15:0] sz_cnt    [8];
    logic [7:0]  edge_pend;
    logic [7:0]  blk_active;
    logic        nmi_stop_enable;

    logic [7:0]  trig_meta;
    logic [7:0]  trig_sync;
    logic [7:0]  trig_prev;
    logic        nmi_meta;
    logic        nmi_sync;
    logic        nmi_prev;
    logic        abort_pend;

    dma_channel_pkg::mover_state_e state;
    logic [2:0]  cur_ch;

    logic        bus_write;
    logic        nmi_rise;
    logic        unit_done;
    logic [7:0]  request;
    logic        any_req;
    logic [2:0]  grant;
    logic [7:0]  irq_pend;

    function automatic logic [19:0] step_addr(input logic [19:0] a, input logic [1:0] sel,
                                              input logic byte_w);
        logic [19:0] amount;
        amount = byte_w ? 20'h00001 : 20'h00002;
        if (sel == dma_channel_pkg::step_inc) begin
            step_addr = a + amount;
        end else if (sel == dma_channel_pkg::step_dec) begin
            step_addr = a - amount;
        end else begin
            step_addr = a;
        end
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
        merge16 = old;
        if (strb[0]) begin
            merge16[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            merge16[15:8] = wd[15:8];
        end
    endfunction

    function automatic logic [19:0] merge_addr(input logic [19:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
        merge_addr = {old[19:16], merge16(old[15:0], wd, strb)};
        if (strb[2]) begin
            merge_addr[19:16] = wd[19:16];
        end else if (strb[0] || strb[1]) begin
            merge_addr[19:16] = 4'h0;
        end
    endfunction

    // two-flop synchronisers, edge detect on the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_meta <= 8'h00;
            trig_sync <= 8'h00;
            trig_prev <= 8'h00;
            nmi_meta  <= 1'b0;
            nmi_sync  <= 1'b0;
            nmi_prev  <= 1'b0;
        end else begin
            trig_meta <= trigger_in;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
            nmi_meta  <= nmi_in;
            nmi_sync  <= nmi_meta;
            nmi_prev  <= nmi_sync;
        end
    end

    assign nmi_rise  = nmi_sync && !nmi_prev;
    assign bus_write = psel && penable && pready && pwrite && !pslverr;
    assign unit_done = (state == dma_channel_pkg::mover_write) && mem_ack;

    // request per channel and fixed priority, channel 0 first
    always_comb begin
        any_req = 1'b0;
        grant   = 3'h0;
        for (int i = 0; i < 8; i++) begin
            request[i] = ctl[i][dma_channel_pkg::enable_pos]
                && (sz_prog[i] != 16'h0000)
                && (ctl[i][dma_channel_pkg::soft_start_pos] || blk_active[i]
                    || (ctl[i][dma_channel_pkg::trig_level_pos] ? trig_sync[i]
                                                                 : edge_pend[i]));
            irq_pend[i] = ctl[i][dma_channel_pkg::done_pos] && ctl[i][dma_channel_pkg::irq_enable_pos];
        end
        for (int i = 7; i >= 0; i--) begin
            if (request[i]) begin
                any_req = 1'b1;
                grant   = i[2:0];
            end
        end
    end

    // register file with the mover's effects applied after software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                ctl[i]      <= dma_channel_pkg::ctl_reset;
                src_prog[i] <= dma_channel_pkg::addr_reset;
                dst_prog[i] <= dma_channel_pkg::addr_reset;
                src_work[i] <= dma_channel_pkg::addr_reset;
                dst_work[i] <= dma_channel_pkg::addr_reset;
                sz_prog[i]  <= dma_channel_pkg::size_reset;
                sz_cnt[i]   <= dma_channel_pkg::size_reset;
            end
            edge_pend       <= 8'h00;
            blk_active      <= 8'h00;
            nmi_stop_enable <= 1'b0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (trig_sync[i] && !trig_prev[i] && ctl[i][dma_channel_pkg::enable_pos]) begin
                    edge_pend[i] <= 1'b1;
                end
            end
            if (bus_write && paddr == dma_channel_pkg::global_cfg_offset && pstrb[0]) begin
                nmi_stop_enable <= pwdata[dma_channel_pkg::nmi_stop_pos];
            end else if (bus_write && paddr[11:7] == dma_channel_pkg::channel_page) begin
                if (paddr[3:2] == dma_channel_pkg::ctl_slot) begin
                    ctl[paddr[6:4]] <= merge16(ctl[paddr[6:4]], pwdata, pstrb)
                                       & dma_channel_pkg::ctl_write_mask;
                    if (pstrb[0] && pwdata[dma_channel_pkg::enable_pos]
                        && !ctl[paddr[6:4]][dma_channel_pkg::enable_pos]) begin
                        src_work[paddr[6:4]] <= src_prog[paddr[6:4]];
                        dst_work[paddr[6:4]] <= dst_prog[paddr[6:4]];
                        sz_cnt[paddr[6:4]]   <= sz_prog[paddr[6:4]];
                        edge_pend[paddr[6:4]] <= 1'b0;
                        blk_active[paddr[6:4]] <= 1'b0;
                    end
                end else if (paddr[3:2] == dma_channel_pkg::src_slot) begin
                    src_prog[paddr[6:4]] <= merge_addr(src_prog[paddr[6:4]], pwdata, pstrb);
                    src_work[paddr[6:4]] <= merge_addr(src_prog[paddr[6:4]], pwdata, pstrb);
                end else if (paddr[3:2] == dma_channel_pkg::dst_slot) begin
                    dst_prog[paddr[6:4]] <= merge_addr(dst_prog[paddr[6:4]], pwdata, pstrb);
                    dst_work[paddr[6:4]] <= merge_addr(dst_prog[paddr[6:4]], pwdata, pstrb);
                end else begin
                    sz_prog[paddr[6:4]] <= merge16(sz_prog[paddr[6:4]], pwdata, pstrb);
                    sz_cnt[paddr[6:4]]  <= merge16(sz_prog[paddr[6:4]], pwdata, pstrb);
                end
            end
            // start of a unit consumes the one-shot requests
            if (state == dma_channel_pkg::mover_idle && any_req
                && !(nmi_rise && nmi_stop_enable)) begin
                if (!(bus_write && paddr[11:7] == dma_channel_pkg::channel_page
                      && paddr[6:4] == grant && paddr[3:2] == dma_channel_pkg::ctl_slot
                      && pstrb[0] && pwdata[dma_channel_pkg::soft_start_pos])) begin
                    ctl[grant][dma_channel_pkg::soft_start_pos] <= 1'b0;
                end
                edge_pend[grant] <= trig_sync[grant] && !trig_prev[grant];
                if (ctl[grant][dma_channel_pkg::mode_lsb +: 2] != 2'h0) begin
                    blk_active[grant] <= 1'b1;
                end
            end
            // nmi stop of channels waiting in a block
            if (nmi_rise && nmi_stop_enable) begin
                for (int i = 0; i < 8; i++) begin
                    if (blk_active[i] && (state == dma_channel_pkg::mover_idle
                                          || cur_ch != i[2:0])) begin
                        blk_active[i] <= 1'b0;
                        ctl[i][dma_channel_pkg::enable_pos] <= 1'b0;
                        ctl[i][dma_channel_pkg::abort_pos]  <= 1'b1;
                    end
                end
            end
            if (unit_done) begin
                src_work[cur_ch] <= step_addr(src_work[cur_ch],
                    ctl[cur_ch][dma_channel_pkg::src_step_lsb +: 2],
                    ctl[cur_ch][dma_channel_pkg::src_width_pos]);
                dst_work[cur_ch] <= step_addr(dst_work[cur_ch],
                    ctl[cur_ch][dma_channel_pkg::dest_step_lsb +: 2],
                    ctl[cur_ch][dma_channel_pkg::dest_width_pos]);
                if (sz_cnt[cur_ch] == 16'h0001) begin
                    sz_cnt[cur_ch]     <= sz_prog[cur_ch];
                    src_work[cur_ch]   <= src_prog[cur_ch];
                    dst_work[cur_ch]   <= dst_prog[cur_ch];
                    blk_active[cur_ch] <= 1'b0;
                    ctl[cur_ch][dma_channel_pkg::done_pos] <= 1'b1;
                    if (!ctl[cur_ch][dma_channel_pkg::mode_lsb + dma_channel_pkg::mode_repeat_bit]) begin
                        ctl[cur_ch][dma_channel_pkg::enable_pos] <= 1'b0;
                    end
                end else begin
                    sz_cnt[cur_ch] <= sz_cnt[cur_ch] - 16'h0001;
                end
                if (abort_pend || (nmi_rise && nmi_stop_enable)) begin
                    blk_active[cur_ch] <= 1'b0;
                    ctl[cur_ch][dma_channel_pkg::enable_pos] <= 1'b0;
                    ctl[cur_ch][dma_channel_pkg::abort_pos]  <= 1'b1;
                end
            end
        end
    end

    // mover: one read then one write per unit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= dma_channel_pkg::mover_idle;
            cur_ch     <= 3'h0;
            mem_req    <= '0;
            abort_pend <= 1'b0;
        end else begin
            if (unit_done) begin
                abort_pend <= 1'b0;
            end else if (nmi_rise && nmi_stop_enable && state != dma_channel_pkg::mover_idle) begin
                abort_pend <= 1'b1;
            end
            case (state)
                dma_channel_pkg::mover_idle: begin
                    if (any_req && !(nmi_rise && nmi_stop_enable)) begin
                        cur_ch              <= grant;
                        state               <= dma_channel_pkg::mover_read;
                        mem_req.valid       <= 1'b1;
                        mem_req.write       <= 1'b0;
                        mem_req.addr        <= src_work[grant];
                        mem_req.byte_access <= ctl[grant][dma_channel_pkg::src_width_pos];
                    end
                end
                dma_channel_pkg::mover_read: begin
                    if (mem_ack) begin
                        state               <= dma_channel_pkg::mover_write;
                        mem_req.write       <= 1'b1;
                        mem_req.addr        <= dst_work[cur_ch];
                        mem_req.byte_access <= ctl[cur_ch][dma_channel_pkg::dest_width_pos];
                        mem_req.wdata       <= ctl[cur_ch][dma_channel_pkg::src_width_pos]
                                               ? {8'h00, mem_rdata[7:0]} : mem_rdata;
                    end
                end
                dma_channel_pkg::mover_write: begin
                    if (mem_ack) begin
                        state         <= dma_channel_pkg::mover_idle;
                        mem_req.valid <= 1'b0;
                        mem_req.write <= 1'b0;
                    end
                end
                default: begin
                    state <= dma_channel_pkg::mover_idle;
                end
            endcase
        end
    end

    // apb answer: pready and read data prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (psel && !penable) begin
                if (paddr == dma_channel_pkg::vector_offset) begin
                    prdata <= 32'h00000000;
                    for (int i = 7; i >= 0; i--) begin
                        if (irq_pend[i]) begin
                            prdata <= {27'h0000000, i[3:0] + 4'h1, 1'b0};
                        end
                    end
                end else if (paddr == dma_channel_pkg::global_cfg_offset) begin
                    prdata <= {31'h00000000, nmi_stop_enable};
                end else if (paddr[11:7] == dma_channel_pkg::channel_page && paddr[1:0] == 2'h0) begin
                    if (paddr[3:2] == dma_channel_pkg::ctl_slot) begin
                        prdata <= {16'h0000, ctl[paddr[6:4]]};
                    end else if (paddr[3:2] == dma_channel_pkg::src_slot) begin
                        prdata <= {12'h000, src_prog[paddr[6:4]]};
                    end else if (paddr[3:2] == dma_channel_pkg::dst_slot) begin
                        prdata <= {12'h000, dst_prog[paddr[6:4]]};
                    end else begin
                        prdata <= {16'h0000, sz_prog[paddr[6:4]]};
                    end
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_irq <= 8'h00;
        end else begin
            channel_irq <= irq_pend;
        end
    end

endmodule // dma_channel_control

`default_nettype wire

// File: dma_channel_control_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dma_channel_control_sva (
    // clock and reset
    input wire logic                      pclk,
    input wire logic                      presetn,
    // apb side
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [11:0]               paddr,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    // memory side and interrupts
    input wire dma_channel_pkg::mem_req_s mem_req,
    input wire logic                      mem_ack,
    input wire logic [7:0]                channel_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_PREADY_AFTER_SETUP: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("answer held too long");
    AST_ERR_RESPONSE: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer malformed");
    AST_VECTOR_FORMAT: assert property (pready && !pslverr && !pwrite && paddr == 12'h000
        |-> prdata <= 32'h10 && !prdata[0]) else $error("vector out of range");
    AST_ADDR_RESERVED: assert property (pready && !pslverr && !pwrite
        && paddr[11:7] == 5'h01 && (paddr[3] ^ paddr[2]) |-> prdata[31:20] == 12'h0)
        else $error("address upper bits not zero");
    AST_REQ_HELD: assert property (mem_req.valid && !mem_ack |=> $stable(mem_req))
        else $error("memory request changed before ack");
    AST_READ_THEN_WRITE: assert property (mem_req.valid && !mem_req.write && mem_ack
        |=> mem_req.valid && mem_req.write) else $error("no write after read");
    AST_UNIT_GAP: assert property (mem_req.valid && mem_req.write && mem_ack
        |=> !mem_req.valid) else $error("no idle cycle after unit");
    AST_IRQ_CAUSE: assert property ($changed(channel_irq)
        |-> $past(mem_ack, 2) || $past(psel && penable && pwrite, 2))
        else $error("interrupt changed without cause");
endmodule // dma_channel_control_sva
`default_nettype wire

// File: dma_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dma_mem_model (
    // clock, reset and random stall
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      stall,
    // request from the engine
    input wire dma_channel_pkg::mem_req_s mem_req,
    // answer
    output logic                          mem_ack,
    output logic [15:0]                   mem_rdata
);
    logic take;

    assign take = mem_req.valid && !mem_ack && !stall;

    // data only valid with ack; otherwise it keeps toggling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 16'h0;
        end else begin
            mem_ack <= take;
            if (take && mem_req.byte_access)
                mem_rdata <= {~mem_req.addr[7:0], mem_req.addr[7:0] ^ 8'h3c};
            else if (take)
                mem_rdata <= mem_req.addr[15:0] ^ 16'h5a3c;
            else
                mem_rdata <= ~mem_rdata;
        end
    end
endmodule // dma_mem_model
`default_nettype wire

// File: test_dma_channel_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_dma_channel_control;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, nmi_in = 0, stall = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, seed = 32'hfafd4d61, seed_s = 32'hfafd4d61;
    logic [3:0]  pstrb = '0;
    logic [7:0]  trigger_in = '0, channel_irq;
    logic        pready, pslverr, mem_ack, err;
    logic [15:0] mem_rdata, c, mk;
    logic [19:0] sa, da;
    logic [37:0] r, w, log_q[$];
    int          err_total = 0, checked = 0, units;
    dma_channel_pkg::mem_req_s mem_req;

    dma_channel_control uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .trigger_in, .nmi_in, .mem_req, .mem_ack, .mem_rdata,
        .channel_irq);
    dma_mem_model mem (.pclk, .presetn, .stall, .mem_req, .mem_ack, .mem_rdata);

    always #10 pclk = ~pclk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    function automatic logic [11:0] ch(input int n, input int s);
        return {dma_channel_pkg::channel_page, 3'(n), 2'(s), 2'b00};
    endfunction

    // address offset of unit u: one per byte, two per word
    function automatic logic [19:0] step(input logic [1:0] code, input logic b, input int u);
        logic [19:0] d;
        d = 20'(u) << !b;
        return code == 2'h3 ? d : code == 2'h2 ? -d : 20'h0;
    endfunction

    always @(posedge pclk) begin
        seed_s <= xs(seed_s);
        stall  <= seed_s[0];
        if (mem_req.valid && mem_ack)
            log_q.push_back({mem_req.write, mem_req.byte_access, mem_req.addr,
                             mem_req.write ? mem_req.wdata : mem_rdata});
    end

    task automatic final_report;
        $display("checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        pstrb  <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            final_report();
        end
        @(posedge pclk);
    endtask

    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        check(name, rd, exp);
    endtask

    task automatic go(input int n, input logic [15:0] cv, input logic [19:0] s, input logic [19:0] d,
                      input logic [15:0] sz);
        apb(1'b1, ch(n, 1), {12'h0, s}, 4'hf);
        apb(1'b1, ch(n, 2), {12'h0, d}, 4'hf);
        apb(1'b1, ch(n, 3), {16'h0, sz}, 4'hf);
        apb(1'b1, ch(n, 0), {16'h0, cv}, 4'hf);
    endtask

    task automatic wait_log(input int n);
        for (int k = 0; k < 2000 && log_q.size() < n; k++)
            @(posedge pclk);
        if (log_q.size() < n) begin
            err_total++;
            final_report();
        end
        repeat (30) @(posedge pclk);
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int n = 0; n < 8; n++) begin
            rdchk("control reset", ch(n, 0), 32'(dma_channel_pkg::ctl_reset));
            rdchk("size reset", ch(n, 3), 32'(dma_channel_pkg::size_reset));
        end
        apb(1'b0, 12'h008, 32'h0, 4'h0);
        check("unmapped error", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        for (int s = 1; s < 3; s++) begin
            seed = xs(seed);
            apb(1'b1, ch(0, s), seed, 4'hf);
            rdchk("address full", ch(0, s), {12'h0, seed[19:0]});
            apb(1'b1, ch(0, s), seed, 4'h3);
            rdchk("address word", ch(0, s), {16'h0, seed[15:0]});
        end
        for (int m = 0; m < 8; m++) begin
            seed = xs(seed);
            sa = seed[19:0] & 20'hffffe;
            da = seed[31:12] & 20'hffffe;
            c = {1'b0, 3'(m), 2'(m), ~2'(m), 1'(m), 1'(m >> 1), 6'h15};
            units = (m % 4 == 0) ? 1 : 2;
            mk = c[7] ? 16'hff : 16'hffff;
            go(0, c, sa, da, 16'h2);
            wait_log(2 * units);
            check("unit count", log_q.size(), 2 * units);
            for (int u = 0; u < units; u++) begin
                r = log_q[2 * u];
                w = log_q[2 * u + 1];
                check("source access", r[37:16], {1'b0, c[6], sa + step(c[9:8], c[6], u)});
                check("dest access", w[37:16], {1'b1, c[7], da + step(c[11:10], c[7], u)});
                check("moved data", w[15:0] & mk, (c[6] ? {8'h0, r[7:0]} : r[15:0]) & mk);
            end
            c[0] = 1'b0;
            c[3] = units == 2;
            c[4] = m > 3 || units == 1;
            rdchk("control after", ch(0, 0), {16'h0, c});
            rdchk("source kept", ch(0, 1), {12'h0, sa});
            rdchk("dest kept", ch(0, 2), {12'h0, da});
            if (units == 2)
                rdchk("size reload", ch(0, 3), 32'h2);
            rdchk("vector", 12'h000, units == 2 ? 32'h2 : 32'h0);
            check("irq", channel_irq, {7'h0, c[3]});
            apb(1'b1, ch(0, 0), 32'h0, 4'hf);
            log_q.delete();
        end
        go(1, 16'h0004, 20'h00100, 20'h00200, 16'h3);
        trigger_in[1] <= 1'b1;
        repeat (10) @(posedge pclk);
        trigger_in[1] <= 1'b0;
        repeat (10) @(posedge pclk);
        check("disabled trigger", log_q.size(), 0);
        apb(1'b1, ch(1, 0), 32'h14, 4'hf);
        trigger_in[1] <= 1'b1;
        wait_log(2);
        check("edge trigger", log_q.size(), 2);
        apb(1'b1, ch(1, 0), 32'h34, 4'hf);
        wait_log(6);
        check("level trigger", log_q.size(), 6);
        trigger_in[1] <= 1'b0;
        apb(1'b1, ch(1, 0), 32'h0, 4'hf);
        go(2, 16'h1015, 20'h00300, 20'h00400, 16'h0);
        repeat (30) @(posedge pclk);
        check("size zero", log_q.size(), 6);
        apb(1'b1, ch(2, 0), 32'h0, 4'hf);
        log_q.delete();
        for (int n = 5; n > 2; n -= 2)
            go(n, 16'h1015, 20'h00500, 20'h00600, 16'h1);
        wait_log(4);
        check("irq pair", channel_irq, 32'h28);
        rdchk("vector high", 12'h000, 32'h8);
        apb(1'b1, ch(3, 0), 32'h0, 4'hf);
        rdchk("vector next", 12'h000, 32'hc);
        apb(1'b1, ch(5, 0), 32'h0, 4'hf);
        rdchk("vector none", 12'h000, 32'h0);
        log_q.delete();
        apb(1'b1, 12'h004, 32'h1, 4'hf);
        go(0, 16'h1015, 20'h00700, 20'h00800, 16'h28);
        wait_log(2);
        nmi_in <= 1'b1;
        repeat (4) @(posedge pclk);
        nmi_in <= 1'b0;
        repeat (40) @(posedge pclk);
        check("whole units", log_q.size() % 2, 0);
        check("stopped early", 32'(log_q.size() < 80), 32'h1);
        rdchk("abort", ch(0, 0), 32'h1006);
        final_report();
    end
endmodule // test_dma_channel_control

bind dma_channel_control dma_channel_control_sva chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .mem_req, .mem_ack, .channel_irq);
`default_nettype wire
